//--- src/blcr_pkg.sv
// package for the backlight i2c configuration register bank
// holds bus address, register offsets, field positions, reset values, types
package blcr_pkg;
  localparam logic [6:0] dev_addr = 7'h46;
  localparam int num_regs = 9;
  localparam logic [7:0] reg_soft_reset_ctrl = 8'h00;
  localparam logic [7:0] reg_channel_disable = 8'h01;
  localparam logic [7:0] reg_phase_and_frequency = 8'h02;
  localparam logic [7:0] reg_gain_and_timers = 8'h03;
  localparam logic [7:0] reg_protection_thresholds = 8'h04;
  localparam logic [7:0] reg_soft_ramp_and_role = 8'h05;
  localparam logic [7:0] reg_open_fault_mask = 8'h06;
  localparam logic [7:0] reg_short_fault_mask = 8'h07;
  localparam logic [7:0] reg_feedback_settings = 8'h08;
  localparam logic [7:0] reg_last = 8'h08;
  localparam logic [7:0] reg_reset_val = 8'h00;
  // implemented-bit masks, unimplemented bits read zero
  localparam logic [7:0] mask_soft_reset_ctrl = 8'h03;
  localparam logic [7:0] mask_channel_disable = 8'h3f;
  localparam logic [7:0] mask_full = 8'hff;
  localparam logic [7:0] mask_soft_ramp_and_role = 8'h3f;
  localparam logic [7:0] mask_short_fault_mask = 8'h3f;
  localparam logic [7:0] mask_feedback_settings = 8'h3f;
  localparam int phase_counter_reset_bit = 0;
  localparam int fault_soft_reset_bit = 1;
  localparam int phase_lsb = 0;
  localparam int phase_msb = 2;

  typedef enum logic [2:0] {
    blcr_idle = 3'b000,
    blcr_addr = 3'b001,
    blcr_ptr = 3'b010,
    blcr_wdata = 3'b011,
    blcr_rdata = 3'b100,
    blcr_ack = 3'b101,
    blcr_rack = 3'b110
  } blcr_state_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } blcr_wr_t;
endpackage : blcr_pkg

//--- src/blcr_regfile.sv
// nine byte-wide configuration registers with registered read data
// assumes write and read requests come from one clock domain
module blcr_regfile #(
  parameter int num_regs = 9
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire blcr_pkg::blcr_wr_t wr, // write request
  input wire logic [7:0] rd_addr, // read pointer
  output logic [7:0] rd_data, // registered read data
  output logic [num_regs*8-1:0] regs_flat // all register contents
);
  logic [7:0] regs_q [num_regs];

  function automatic logic [7:0] bit_mask(input logic [7:0] a);
    if (a == blcr_pkg::reg_soft_reset_ctrl) bit_mask = blcr_pkg::mask_soft_reset_ctrl;
    else if (a == blcr_pkg::reg_channel_disable) bit_mask = blcr_pkg::mask_channel_disable;
    else if (a == blcr_pkg::reg_soft_ramp_and_role) bit_mask = blcr_pkg::mask_soft_ramp_and_role;
    else if (a == blcr_pkg::reg_short_fault_mask) bit_mask = blcr_pkg::mask_short_fault_mask;
    else if (a == blcr_pkg::reg_feedback_settings) bit_mask = blcr_pkg::mask_feedback_settings;
    else bit_mask = blcr_pkg::mask_full;
  endfunction : bit_mask

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < num_regs; i++) regs_q[i] <= blcr_pkg::reg_reset_val;
    end else if (wr.we && wr.addr <= blcr_pkg::reg_last) begin
      regs_q[wr.addr[3:0]] <= wr.data & bit_mask(wr.addr);
    end
  end

  // out-of-range pointers read zero; host must not rely on them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rd_data <= 8'h00;
    else if (rd_addr <= blcr_pkg::reg_last) rd_data <= regs_q[rd_addr[3:0]];
    else rd_data <= 8'h00;
  end

  always_comb begin
    for (int i = 0; i < num_regs; i++) regs_flat[i*8 +: 8] = regs_q[i];
  end
endmodule : blcr_regfile

//--- src/blcr_top.sv
// i2c slave and configuration register bank of a six-channel backlight driver
// assumes scl is the link clock port; sda is split into in/out/enable
// Notes on behaviour
// - first byte after start is 7-bit address, msb first, then read-high direction bit
// - answer only bus address 46h
// - receiver drives low acknowledge after each byte; high means no acknowledge
// - in a write the byte after the address is a one-byte pointer, msb first
// - data bytes travel msb first, each followed by an acknowledge slot
// - registers 00h to 08h are writable and readable
// - unimplemented bits ignore writes and read zero
// - most fields take effect as soon as the write completes
// - phase-shift field is held pending until next pwm rising edge
// - channel disables take effect only while pwm is low
// - writes accepted at any time, regardless of standby or pwm
// - fault soft reset bit clears latched protection and releases fault output
// - fault soft reset bit clears like fault reset pin high, but also masks latch-off; the pin does not
// - while fault soft reset bit is one, latch-off protection is suppressed
// - read without pointer returns register 00h
// - pointer write, repeated start, read; single or multi byte
// - several data bytes may follow one pointer in a write
// - phase counter reset bit holds phase logic reset while set
module blcr_top #(
  parameter int num_regs = 9
) (
  input wire logic clk, // 50 mhz system clock
  input wire logic rst_b, // async reset, active low
  input wire logic scl, // i2c clock, link domain
  input wire logic sda_i, // i2c data level on the wire
  output logic sda_o, // i2c data drive value, always low
  output logic sda_oe, // high while pulling sda low
  input wire logic pwm_i, // pwm dimming input pin
  input wire logic fault_reset_pin_i, // external fault reset pin
  output logic [5:0] channel_disable_o, // applied channel disables
  output logic [2:0] phase_select_o, // applied phase shift select
  output logic [4:0] frequency_multiplier_o, // frequency multiplier
  output logic [7:0] gain_and_timers_o, // gain and timers field
  output logic [7:0] protection_thresholds_o, // protection thresholds
  output logic [5:0] soft_ramp_and_role_o, // soft ramp and role fields
  output logic [7:0] open_fault_mask_o, // open fault masks
  output logic [5:0] short_fault_mask_o, // short fault masks
  output logic [5:0] feedback_settings_o, // feedback settings
  output logic phase_logic_reset_o, // holds phase logic in reset
  output logic protection_clear_o, // clears latched protection, fault pin release
  output logic latch_off_suppress_o // masks latch-off protection actions
);
  ////////////////////////////////////////////////////////////////////////////
  // link domain: start/stop detect and bit engine on scl
  // start/stop are sda edges while scl high; sampled by sda-edge flops
  logic start_tgl_q;
  logic stop_tgl_q;
  logic start_seen_q;
  logic start_ack_q;
  always_ff @(negedge sda_i or negedge rst_b) begin
    if (!rst_b) start_tgl_q <= 1'b0;
    else if (scl) start_tgl_q <= ~start_tgl_q;
  end
  always_ff @(posedge sda_i or negedge rst_b) begin
    if (!rst_b) stop_tgl_q <= 1'b0;
    else if (scl) stop_tgl_q <= ~stop_tgl_q;
  end
  // a start stays pending until the bit engine acknowledges it on scl
  assign start_seen_q = start_tgl_q ^ start_ack_q;

  blcr_pkg::blcr_state_t st_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic first_q;
  logic [7:0] ptr_q;
  logic wr_tgl_q;
  logic [7:0] wr_data_q;
  logic [7:0] wr_addr_q;
  logic drive_q;
  logic [7:0] tx_q;
  logic ack_ok_q;
  logic [7:0] rd_sync_data;
  logic stop_ack_q;
  logic stop_seen;
  // a stop since the last scl rise marks the next start as a fresh transfer
  assign stop_seen = stop_tgl_q ^ stop_ack_q;

  // shift in on rising scl
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= blcr_pkg::blcr_idle;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ptr_q <= 8'h00;
      wr_tgl_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_addr_q <= 8'h00;
      start_ack_q <= 1'b0;
      stop_ack_q <= 1'b0;
      ack_ok_q <= 1'b0;
    end else if (start_seen_q) begin
      start_ack_q <= start_tgl_q;
      stop_ack_q <= stop_tgl_q;
      st_q <= blcr_pkg::blcr_addr;
      bit_cnt_q <= 3'h6;
      // first address bit arrives on the edge that sees the start
      shift_q <= {7'h00, sda_i};
      // fresh transfer reads from 00h; a repeated start keeps the pointer
      if (stop_seen) ptr_q <= 8'h00;
    end else begin
      stop_ack_q <= stop_tgl_q;
      case (st_q)
        blcr_pkg::blcr_idle: begin
          // foreign address or finished read: wait for the next start
          st_q <= blcr_pkg::blcr_idle;
        end
        blcr_pkg::blcr_addr: begin
          shift_q <= {shift_q[6:0], sda_i};
          if (bit_cnt_q == 3'h0) begin
            rw_q <= sda_i;
            ack_ok_q <= (shift_q[6:0] == blcr_pkg::dev_addr);
            st_q <= (shift_q[6:0] == blcr_pkg::dev_addr) ? blcr_pkg::blcr_ack : blcr_pkg::blcr_idle;
            first_q <= 1'b1;
          end else begin
            bit_cnt_q <= bit_cnt_q - 3'h1;
          end
        end
        blcr_pkg::blcr_ack: begin
          bit_cnt_q <= 3'h7;
          shift_q <= 8'h00;
          // a pointer byte follows only a write address
          st_q <= rw_q ? blcr_pkg::blcr_rdata : (first_q ? blcr_pkg::blcr_ptr : blcr_pkg::blcr_wdata);
        end
        blcr_pkg::blcr_ptr, blcr_pkg::blcr_wdata: begin
          shift_q <= {shift_q[6:0], sda_i};
          if (bit_cnt_q == 3'h0) begin
            if (st_q == blcr_pkg::blcr_ptr) begin
              ptr_q <= {shift_q[6:0], sda_i};
            end else begin
              wr_addr_q <= ptr_q;
              wr_data_q <= {shift_q[6:0], sda_i};
              wr_tgl_q <= ~wr_tgl_q;
              ptr_q <= ptr_q + 8'h01;
            end
            first_q <= 1'b0;
            st_q <= blcr_pkg::blcr_ack;
          end else begin
            bit_cnt_q <= bit_cnt_q - 3'h1;
          end
        end
        blcr_pkg::blcr_rdata: begin
          // fetch ahead so the next byte settles across domains before the rack fall
          if (bit_cnt_q == 3'h7) ptr_q <= ptr_q + 8'h01;
          if (bit_cnt_q == 3'h0) begin
            st_q <= blcr_pkg::blcr_rack;
          end else begin
            bit_cnt_q <= bit_cnt_q - 3'h1;
          end
        end
        blcr_pkg::blcr_rack: begin
          bit_cnt_q <= 3'h7;
          // a master nack ends the read
          st_q <= sda_i ? blcr_pkg::blcr_idle : blcr_pkg::blcr_rdata;
        end
        default: st_q <= blcr_pkg::blcr_idle;
      endcase
    end
  end

  // drive on falling scl: ack slots and read bits
  always_ff @(negedge scl or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      case (st_q)
        blcr_pkg::blcr_ack: begin
          drive_q <= ack_ok_q;
          tx_q <= rd_sync_data;
        end
        blcr_pkg::blcr_rdata: begin
          drive_q <= ~tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
        blcr_pkg::blcr_rack: begin
          drive_q <= 1'b0;
          tx_q <= rd_sync_data;
        end
        default: drive_q <= 1'b0;
      endcase
    end
  end
  // open drain: the pad only ever pulls low
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) sda_o <= 1'b0;
    else sda_o <= 1'b0;
  end
  assign sda_oe = drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: write handshake by toggle, read pointer by two flops
  // one toggle flip per written byte, so no byte is lost or doubled
  logic [2:0] wr_sync_q;
  logic [7:0] wr_addr_s_q;
  logic [7:0] wr_data_s_q;
  blcr_pkg::blcr_wr_t wr;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wr_sync_q <= 3'h0;
    else wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
  end
  // write words are stable long before the toggle arrives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_addr_s_q <= 8'h00;
      wr_data_s_q <= 8'h00;
    end else begin
      wr_addr_s_q <= wr_addr_q;
      wr_data_s_q <= wr_data_q;
    end
  end
  assign wr.we = wr_sync_q[2] ^ wr_sync_q[1];
  assign wr.addr = wr_addr_s_q;
  assign wr.data = wr_data_s_q;

  // pointer settles at least seven and a half scl periods before it is used
  logic [7:0] ptr_s1_q;
  logic [7:0] ptr_s2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_s1_q <= 8'h00;
      ptr_s2_q <= 8'h00;
    end else begin
      ptr_s1_q <= ptr_q;
      ptr_s2_q <= ptr_s1_q;
    end
  end

  logic [num_regs*8-1:0] regs_flat;
  logic [7:0] rd_data;
  // read data comes out of a register, one clock behind the pointer
  blcr_regfile #(.num_regs(num_regs)) u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .wr(wr),
    .rd_addr(ptr_s2_q),
    .rd_data(rd_data),
    .regs_flat(regs_flat)
  );
  // read data is held stable across the ack slot; scl is far slower than clk
  assign rd_sync_data = rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and field application
  // pwm edge detector idles low like the pin, so no false edge after reset
  logic [1:0] pwm_sync_q;
  logic pwm_prev_q;
  logic [1:0] frst_sync_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_sync_q <= 2'b00;
      pwm_prev_q <= 1'b0;
      frst_sync_q <= 2'b00;
    end else begin
      pwm_sync_q <= {pwm_sync_q[0], pwm_i};
      pwm_prev_q <= pwm_sync_q[1];
      frst_sync_q <= {frst_sync_q[0], fault_reset_pin_i};
    end
  end

  // register slices for offsets 00h to 02h; the fields of 03h to 08h pick their bits from regs_flat directly
  logic [7:0] r_soft;
  logic [7:0] r_dis;
  logic [7:0] r_phf;
  assign r_soft = regs_flat[0 +: 8];
  assign r_dis = regs_flat[8 +: 8];
  assign r_phf = regs_flat[16 +: 8];

  // pending value waits in the register until the next pulse starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) phase_select_o <= 3'h0;
    else if (pwm_sync_q[1] && !pwm_prev_q) phase_select_o <= r_phf[blcr_pkg::phase_msb:blcr_pkg::phase_lsb];
  end

  // never changes inside a pwm high, so no channel is cut mid-pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) channel_disable_o <= 6'h00;
    else if (!pwm_sync_q[1]) channel_disable_o <= r_dis[5:0];
  end

  // direct fields follow the register one clock after the write lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) frequency_multiplier_o <= 5'h00;
    else frequency_multiplier_o <= r_phf[7:3];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) gain_and_timers_o <= 8'h00;
    else gain_and_timers_o <= regs_flat[24 +: 8];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) protection_thresholds_o <= 8'h00;
    else protection_thresholds_o <= regs_flat[32 +: 8];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) soft_ramp_and_role_o <= 6'h00;
    else soft_ramp_and_role_o <= regs_flat[45:40];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) open_fault_mask_o <= 8'h00;
    else open_fault_mask_o <= regs_flat[48 +: 8];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) short_fault_mask_o <= 6'h00;
    else short_fault_mask_o <= regs_flat[61:56];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) feedback_settings_o <= 6'h00;
    else feedback_settings_o <= regs_flat[69:64];
  end

  // holds the phase counters only, never the register bank
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) phase_logic_reset_o <= 1'b0;
    else phase_logic_reset_o <= r_soft[blcr_pkg::phase_counter_reset_bit];
  end

  // pin and soft bit share one clear path, so both act alike
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) protection_clear_o <= 1'b0;
    else protection_clear_o <= r_soft[blcr_pkg::fault_soft_reset_bit] | frst_sync_q[1];
  end

  // masking follows the soft bit only; the pin clears but does not mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) latch_off_suppress_o <= 1'b0;
    else latch_off_suppress_o <= r_soft[blcr_pkg::fault_soft_reset_bit];
  end
endmodule : blcr_top

//--- tb/blcr_checker.sv
// checker for the blcr_top port rules
// assumes bind onto blcr_top, all sampled on clk
module blcr_checker #(
  parameter int num_regs = 9
) (
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic scl, // bus clock
  input wire logic sda_o, // drive value
  input wire logic sda_oe, // pull enable
  input wire logic pwm_i, // pwm pin
  input wire logic fault_reset_pin_i, // fault pin
  input wire logic [5:0] channel_disable_o, // disables
  input wire logic [2:0] phase_select_o, // phase
  input wire logic protection_clear_o, // clear
  input wire logic latch_off_suppress_o // suppress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] oe_cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) oe_cnt_q <= 8'h00;
    else oe_cnt_q <= sda_oe ? oe_cnt_q + 8'h01 : 8'h00;
  end
  // pins pass a two-flop synchroniser, so causes lie 2 to 4 cycles back
  sequence pin_held;
    fault_reset_pin_i [*4];
  endsequence
  sequence pin_was_high;
    $past(fault_reset_pin_i, 2) || $past(fault_reset_pin_i, 3) || $past(fault_reset_pin_i, 4);
  endsequence
  sequence pwm_was_high;
    $past(pwm_i, 2) || $past(pwm_i, 3) || $past(pwm_i, 4);
  endsequence
  sequence pwm_was_low;
    !$past(pwm_i, 2) || !$past(pwm_i, 3) || !$past(pwm_i, 4);
  endsequence
  suppress_clear_a: assert property (latch_off_suppress_o |-> protection_clear_o)
    else $error("suppress without clear");
  pin_clear_a: assert property (pin_held |=> protection_clear_o)
    else $error("fault pin ignored");
  clear_cause_a: assert property (protection_clear_o && !latch_off_suppress_o |-> pin_was_high)
    else $error("clear without cause");
  disable_pwm_a: assert property ($changed(channel_disable_o) |-> pwm_was_low)
    else $error("disables moved while pwm high");
  phase_rise_a: assert property ($changed(phase_select_o) |-> pwm_was_high)
    else $error("phase moved without pwm rise");
  sda_low_only_a: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda moved while scl high");
  oe_bounded_a: assert property (oe_cnt_q < 8'hc8)
    else $error("sda held low too long");
endmodule : blcr_checker
bind blcr_top blcr_checker #(.num_regs(num_regs)) u_blcr_checker (.clk, .rst_b, .scl, .sda_o, .sda_oe, .pwm_i,
  .fault_reset_pin_i, .channel_disable_o, .phase_select_o, .protection_clear_o, .latch_off_suppress_o);

//--- tb/blcr_host.sv
// host master model: bit-level i2c master
// assumes the bench resolves sda with a pull-up
module blcr_host (
  output logic scl, // bus clock
  output logic sda_h, // 0 pulls sda low
  input wire logic sda // wire level
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // 125 ns bit period; sda moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    #62.5 scl = 1'b1;
    r = sda;
    #62.5 scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda_h = 1'b1;
    #62.5 scl = 1'b1;
    #62.5 sda_h = 1'b0;
    #62.5 scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_h = 1'b0;
    #62.5 scl = 1'b1;
    #62.5 sda_h = 1'b1;
    #62.5;
  endtask : stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask : get_byte
endmodule : blcr_host

//--- tb/blcr_top_tb.sv
// testbench for the backlight i2c register bank
// assumes blcr_host as bus master and the bound checker
module blcr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pwm_i = 1'b0;
  logic frp = 1'b0;
  logic scl, sda_h, sda, sda_o, sda_oe, plr, pcl, los;
  logic [5:0] chd, srr, sfm, fbs;
  logic [2:0] phs;
  logic [4:0] fmu;
  logic [7:0] gat, pth, ofm, res;
  logic [7:0] m [9];
  logic [7:0] wd [9];
  logic [7:0] exp_q [$];
  logic [7:0] mk [9] = '{8'h03, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'h3f};
  int fail_count = 0;
  int samples_checked = 0;
  event res_ev;
  always #10 clk = ~clk;
  assign sda = sda_h & (sda_oe ? sda_o : 1'b1);
  blcr_host host (.scl(scl), .sda_h(sda_h), .sda(sda));
  blcr_top u_blcr_top (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .pwm_i(pwm_i), .fault_reset_pin_i(frp), .channel_disable_o(chd), .phase_select_o(phs),
    .frequency_multiplier_o(fmu), .gain_and_timers_o(gat), .protection_thresholds_o(pth),
    .soft_ramp_and_role_o(srr), .open_fault_mask_o(ofm), .short_fault_mask_o(sfm),
    .feedback_settings_o(fbs), .phase_logic_reset_o(plr), .protection_clear_o(pcl),
    .latch_off_suppress_o(los));
  ////////////////////////////////////////////////////////////
  always @(res_ev) begin
    samples_checked++;
    if (exp_q.size() == 0 || res !== exp_q.pop_front()) begin
      fail_count++;
      $display("CHECK FAILED %0t: got %h", $time, res);
    end
  end
  // the 1 ns gap lets the watcher take each result before the next
  task automatic note(input logic [7:0] e, input logic [7:0] v);
    exp_q.push_back(e);
    res = v;
    ->res_ev;
    #1;
  endtask : note
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] p, input int n);
    logic a;
    host.start();
    host.put_byte({blcr_pkg::dev_addr, 1'b0}, a);
    note(8'h00, {7'h00, a});
    host.put_byte(p, a);
    note(8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      host.put_byte(wd[i], a);
      m[p + i] = wd[i] & mk[p + i];
      note(8'h00, {7'h00, a});
    end
    host.stop();
    repeat (4) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] p, input int n, input logic use_ptr);
    logic a;
    logic [7:0] v;
    if (use_ptr) begin
      host.start();
      host.put_byte({blcr_pkg::dev_addr, 1'b0}, a);
      host.put_byte(p, a);
    end
    host.start();
    host.put_byte({blcr_pkg::dev_addr, 1'b1}, a);
    note(8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      host.get_byte(i == n - 1, v);
      note(m[p + i], v);
    end
    host.stop();
  endtask : rd
  task automatic chk_fields();
    note({3'h0, m[2][7:3]}, {3'h0, fmu});
    note(m[3], gat);
    note(m[4], pth);
    note(m[5], {2'b00, srr});
    note(m[6], ofm);
    note(m[7], {2'b00, sfm});
    note(m[8], {2'b00, fbs});
    note({6'h00, m[0][1:0]}, {6'h00, los, plr});
  endtask : chk_fields
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    logic ack;
    void'($urandom(32'h42aebc13));
    foreach (m[i]) m[i] = 8'h00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h00, 1, 1'b0);
    rd(8'h00, 9, 1'b1);
    chk_fields();
    host.start();
    host.put_byte({7'h47, 1'b0}, ack);
    note(8'h01, {7'h00, ack});
    host.put_byte(8'h01, ack);
    note(8'h01, {7'h00, ack});
    host.stop();
    @(posedge clk);
    pwm_i <= 1'b1;
    foreach (wd[i]) wd[i] = 8'($urandom());
    wr(8'h00, 9);
    chk_fields();
    note(8'h00, {2'b00, chd});
    note(8'h00, {5'h00, phs});
    @(posedge clk);
    pwm_i <= 1'b0;
    repeat (8) @(posedge clk);
    note(m[1], {2'b00, chd});
    note(8'h00, {5'h00, phs});
    @(posedge clk);
    pwm_i <= 1'b1;
    repeat (8) @(posedge clk);
    note({5'h00, m[2][2:0]}, {5'h00, phs});
    rd(8'h00, 9, 1'b1);
    rd(8'h00, 1, 1'b0);
    wd[0] = 8'h02;
    wr(8'h00, 1);
    note(8'h06, {5'h00, pcl, los, plr});
    wd[0] = 8'h01;
    wr(8'h00, 1);
    note(8'h01, {5'h00, pcl, los, plr});
    @(posedge clk);
    frp <= 1'b1;
    repeat (6) @(posedge clk);
    note(8'h05, {5'h00, pcl, los, plr});
    @(posedge clk);
    frp <= 1'b0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (m[i]) m[i] = 8'h00;
    @(posedge clk);
    chk_fields();
    final_report();
  end
endmodule : blcr_top_tb
